// ---- core/psrp_pkg.sv ----
// constants, register map and field layout of the port status page
package psrp_pkg;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_IRQ_STATUS   = 5'h06;
  localparam logic [4:0] IDX_PAGE_SELECT  = 5'h07;
  localparam logic [4:0] IDX_LINE_CONNECT = 5'h08;
  localparam logic [4:0] IDX_SPEED_FAULT  = 5'h09;
  localparam logic [4:0] IDX_ATTACH_SPEED = 5'h0a;
  localparam logic [4:0] IDX_LINK_QUALITY = 5'h0b;
  localparam logic [4:0] IDX_BAD_CODEWORD = 5'h0c;
  localparam logic [4:0] IDX_LOOP_STANDBY = 5'h0d;
  localparam logic [4:0] IDX_SPARE_A      = 5'h0e;
  localparam logic [4:0] IDX_SPARE_B      = 5'h0f;

  // page select register fields
  localparam int PAGE_LSB = 5;
  localparam int PORT_LSB = 0;
  localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;

  // line connect register fields (bit 7 is the leftmost position)
  localparam int FIRST_PAIR_LSB  = 6;
  localparam int SECOND_PAIR_LSB = 4;
  localparam int ROLE_BIT        = 3;
  localparam int CONNECT_BIT     = 2;
  localparam int RECEIVE_OK_BIT  = 1;
  localparam int DISABLE_BIT     = 0;

  // speed and fault register fields
  localparam int NEG_SPEED_LSB   = 5;
  localparam int IRQ_ENABLE_BIT  = 4;
  localparam int FAULT_BIT       = 3;
  localparam int STANDBY_ERR_BIT = 2;
  localparam int SCRAMBLE_OFF_BIT = 1;
  localparam int BETA_ONLY_BIT   = 0;

  // attach and speed capability register fields
  localparam int DIRECT_ATTACH_BIT = 7;
  localparam int MAX_SPEED_LSB     = 4;
  localparam int LOCAL_PLUG_BIT    = 3;
  localparam int CABLE_SPEED_LSB   = 0;

  // link quality and loop/standby register fields
  localparam int UNRELIABLE_BIT   = 7;
  localparam int BETA_MODE_BIT    = 3;
  localparam int LOOP_DISABLE_BIT = 2;
  localparam int IN_STANDBY_BIT   = 1;
  localparam int HARD_DISABLE_BIT = 0;

  // interrupt status register field
  localparam int IRQ_FLAG_BIT = 0;

  // speed coding
  localparam logic [2:0] SPEED_S100  = 3'h0;
  localparam logic [2:0] SPEED_S200  = 3'h1;
  localparam logic [2:0] SPEED_S400  = 3'h2;
  localparam logic [2:0] SPEED_S800  = 3'h3;
  localparam logic [2:0] SPEED_S1600 = 3'h4;
  localparam logic [2:0] SPEED_S3200 = 3'h5;

  // fixed field values
  localparam logic BETA_ONLY_VALUE  = 1'b0;
  localparam logic LOCAL_PLUG_VALUE = 1'b1;
  localparam logic [7:0] BAD_COUNT_MAX = 8'hff;

  // connection debounce time
  localparam int DEBOUNCE_MS = 341;
  localparam int CLK_KHZ     = 25000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;

  // synchronised pin fields per port
  localparam int PIN_W = 19;

endpackage

// ---- core/psrp_port_status_page.sv ----
// per-port status and control register page with an avalon-mm slave
//
// Overview of operation
// - first pair level field: 11 high-z, 01 one, 10 zero, 00 invalid.
// - second pair level field uses the same two-bit coding.
// - role reads 1 child, 0 parent; idle ports read child.
// - legacy connection bit sets only after 341 ms of stable physical connection.
// - connection bit clears on hardware reset, kept across bus reset.
// - beta ports connect once tones seen and speed negotiation done.
// - receive-ok shows debounced bias (legacy) or valid signal (beta).
// - beta port seeing only tones reads receive-ok false.
// - disabled port never becomes active but still sends tones.
// - disable bit resets to zero, untouched by bus reset.
// - agreed speed set at beta connection or from self-id in legacy.
// - enabled port event sets irq flag and notifies link; enable resets 0.
// - resume or suspend fault sets fault bit and keeps port suspended.
// - writing 1 clears fault; hardware reset clears it.
// - standby error sets; cleared by leaving standby, write 1, remote.
// - scrambler-off bit sends packet data unscrambled.
// - beta-only capability bit always reads zero.
// - direct-attach bit shows dc connection found by connect detect.
// - page 0 at indices 8-15 shows chosen port; absent port reads 0.
// - speed coding 000 S100 up to 101 S3200; 110, 111 reserved.
// - bad codeword count saturates at 255 and clears on any read.
`timescale 1ns/100ps
`default_nettype none

module psrp_port_status_page
  import psrp_pkg::*;
#(
  parameter int         NUM_PORTS    = 3,
  parameter int         DEBOUNCE_CYC = DEBOUNCE_CYCLES,
  parameter logic [2:0] CABLE_SPEED  = SPEED_S800
)(
  input  wire logic                   clk,
  input  wire logic                   rst,
  // avalon-mm slave
  input  wire logic [6:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // pins from the port circuits, asynchronous
  input  wire logic [2*NUM_PORTS-1:0] first_pair,
  input  wire logic [2*NUM_PORTS-1:0] second_pair,
  input  wire logic [NUM_PORTS-1:0]   downstream_role,
  input  wire logic [NUM_PORTS-1:0]   phys_connect,
  input  wire logic [NUM_PORTS-1:0]   beta_mode,
  input  wire logic [NUM_PORTS-1:0]   tones_seen,
  input  wire logic [NUM_PORTS-1:0]   tones_only,
  input  wire logic [NUM_PORTS-1:0]   speed_neg_done,
  input  wire logic [NUM_PORTS-1:0]   cable_bias,
  input  wire logic [NUM_PORTS-1:0]   signal_valid,
  input  wire logic [NUM_PORTS-1:0]   direct_attach_detect,
  input  wire logic [NUM_PORTS-1:0]   resume_fault,
  input  wire logic [NUM_PORTS-1:0]   suspend_fault,
  input  wire logic [NUM_PORTS-1:0]   in_standby,
  input  wire logic [NUM_PORTS-1:0]   standby_error,
  input  wire logic [NUM_PORTS-1:0]   loop_disabled,
  input  wire logic [NUM_PORTS-1:0]   hard_disabled,
  input  wire logic [NUM_PORTS-1:0]   sync_failed,
  // same-clock events from the port logic
  input  wire logic [3*NUM_PORTS-1:0] beta_speed,
  input  wire logic [3*NUM_PORTS-1:0] selfid_speed,
  input  wire logic [NUM_PORTS-1:0]   selfid_speed_load,
  input  wire logic [NUM_PORTS-1:0]   port_event,
  input  wire logic [NUM_PORTS-1:0]   invalid_codeword,
  input  wire logic [NUM_PORTS-1:0]   remote_count_read,
  input  wire logic [NUM_PORTS-1:0]   remote_standby_clear,
  // controls to the port circuits
  output logic [NUM_PORTS-1:0]        port_disable,
  output logic [NUM_PORTS-1:0]        scramble_off,
  output logic [NUM_PORTS-1:0]        port_suspend,
  output logic [3*NUM_PORTS-1:0]      max_speed_limit,
  output logic [NUM_PORTS-1:0]        standby_err_clear,
  output logic                        port_event_irq_flag,
  output logic                        link_notify
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  initial
  begin
    if (NUM_PORTS < 1 || NUM_PORTS > 16)
      $error("psrp: NUM_PORTS must be 1..16");
    if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= (1 << 24))
      $error("psrp: DEBOUNCE_CYC out of counter range");
    if (CABLE_SPEED > SPEED_S3200)
      $error("psrp: CABLE_SPEED uses a reserved code");
  end

  localparam logic [23:0] DEB_LAST = 24'(DEBOUNCE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle on every access

  logic        ack_r;
  logic [31:0] rdata_r;
  logic [2:0]  page_r;
  logic [3:0]  port_r;
  logic        irq_flag_r;
  logic        notify_r;
  logic [4:0]  idx;
  logic        acc_wr;
  logic        acc_rd;
  logic        lane0;
  logic [7:0]  wbyte;
  logic        page_ok;
  logic [7:0]  page_word;
  logic [7:0]  rd_byte;

  assign idx             = avs_address[6:2];
  assign lane0           = avs_byteenable[0];
  assign wbyte           = avs_writedata[7:0];
  assign acc_wr          = avs_write & ack_r & lane0;
  assign acc_rd          = avs_read & ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign page_ok = (page_r == PAGE_PORT_STATUS) &&
                   (32'(port_r) < NUM_PORTS);

  // ack toggles so back-to-back requests each see one wait cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // page and port choice, kept here since the page needs it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_r <= 3'h0;
      port_r <= 4'h0;
    end
    else if (acc_wr && idx == IDX_PAGE_SELECT)
    begin
      page_r <= wbyte[PAGE_LSB +: 3];
      port_r <= wbyte[PORT_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port state

  logic [7:0] view [NUM_PORTS][4];
  logic [7:0] view_cnt [NUM_PORTS];
  logic [7:0] view_loop [NUM_PORTS];
  logic [NUM_PORTS-1:0] event_hit;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      logic [PIN_W-1:0] meta_r;
      logic [PIN_W-1:0] pin_r;
      logic [PIN_W-1:0] pin_raw;
      logic [23:0] deb_cnt_r;
      logic        con_r;
      logic        con_q_r;
      logic        stby_q_r;
      logic        dis_r;
      logic        ie_r;
      logic        fault_r;
      logic        stby_flt_r;
      logic        scr_r;
      logic        unrel_r;
      logic [2:0]  maxspd_r;
      logic [2:0]  negspd_r;
      logic [7:0]  badcnt_r;
      logic        stby_clr_r;
      logic        sel;
      logic        wr_here;
      logic        rx_ok;
      logic        role;
      logic        stby_clear;
      logic        con_nxt;
      logic [2:0]  bspd;

      // pin fields
      assign pin_raw = {first_pair[2*p +: 2], second_pair[2*p +: 2],
                        downstream_role[p], phys_connect[p], beta_mode[p],
                        tones_seen[p], tones_only[p], speed_neg_done[p],
                        cable_bias[p], signal_valid[p],
                        direct_attach_detect[p], resume_fault[p],
                        suspend_fault[p], in_standby[p], standby_error[p],
                        loop_disabled[p], hard_disabled[p]};
      // sync_failed goes through its own two-stage chain, uf_r, below
      logic [1:0] uf_r;

      // two-stage synchroniser; only pin_r and uf_r[1] are read by logic
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r <= '0;
          pin_r  <= '0;
          uf_r   <= 2'b00;
        end
        else
        begin
          meta_r <= pin_raw;
          pin_r  <= meta_r;
          uf_r   <= {uf_r[0], sync_failed[p]};
        end
      end

      logic fp1, fp0, sp1, sp0, role_s, conn_s, beta_s, tone_s, tonly_s;
      logic neg_s, bias_s, valid_s, dca_s, rflt_s, sflt_s, stby_s;
      logic serr_s, loop_s, hdis_s;
      assign {fp1, fp0, sp1, sp0, role_s, conn_s, beta_s, tone_s, tonly_s,
              neg_s, bias_s, valid_s, dca_s, rflt_s, sflt_s, stby_s,
              serr_s, loop_s, hdis_s} = pin_r;

      assign sel     = page_ok && (port_r == 4'(p));
      assign wr_here = acc_wr & sel;

      // debounce in legacy mode; beta connects on tones plus speed agreed
      always_comb
      begin
        if (beta_s)
          con_nxt = tone_s & neg_s;
        else
          con_nxt = conn_s && (con_r || deb_cnt_r == DEB_LAST);
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          deb_cnt_r <= 24'h0;
          con_r     <= 1'b0;
          con_q_r   <= 1'b0;
        end
        else
        begin
          if (!conn_s || beta_s)
            deb_cnt_r <= 24'h0;
          else if (deb_cnt_r != DEB_LAST)
            deb_cnt_r <= deb_cnt_r + 24'h1;
          con_r   <= con_nxt;
          con_q_r <= con_r;
        end
      end

      // software controls; bus reset has no path into them
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          dis_r    <= 1'b0;
          ie_r     <= 1'b0;
          scr_r    <= 1'b0;
          maxspd_r <= CABLE_SPEED;
        end
        else
        begin
          if (wr_here && idx == IDX_LINE_CONNECT)
            dis_r <= wbyte[DISABLE_BIT];
          if (wr_here && idx == IDX_SPEED_FAULT)
          begin
            ie_r  <= wbyte[IRQ_ENABLE_BIT];
            scr_r <= wbyte[SCRAMBLE_OFF_BIT];
          end
          // too-fast requests store the port's own capability
          if (wr_here && idx == IDX_ATTACH_SPEED)
            maxspd_r <= (wbyte[MAX_SPEED_LSB +: 3] > CABLE_SPEED) ?
                        CABLE_SPEED : wbyte[MAX_SPEED_LSB +: 3];
        end
      end

      // sticky faults: the setting event wins over a same-cycle clear
      assign stby_clear = (stby_q_r & ~stby_s) | remote_standby_clear[p] |
                          (wr_here && idx == IDX_SPEED_FAULT &&
                           wbyte[STANDBY_ERR_BIT]);
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          fault_r    <= 1'b0;
          stby_flt_r <= 1'b0;
          unrel_r    <= 1'b0;
          stby_q_r   <= 1'b0;
          stby_clr_r <= 1'b0;
        end
        else
        begin
          stby_q_r <= stby_s;
          if (rflt_s | sflt_s)
            fault_r <= 1'b1;
          else if (wr_here && idx == IDX_SPEED_FAULT && wbyte[FAULT_BIT])
            fault_r <= 1'b0;
          if (serr_s)
            stby_flt_r <= 1'b1;
          else if (stby_clear)
            stby_flt_r <= 1'b0;
          // tells the port to drop its standby error state
          stby_clr_r <= stby_clear & ~serr_s & stby_flt_r;
          if (uf_r[1])
            unrel_r <= 1'b1;
          else if (wr_here && idx == IDX_LINK_QUALITY &&
                   wbyte[UNRELIABLE_BIT])
            unrel_r <= 1'b0;
        end
      end

      // agreed speed, capped by the software speed limit in beta mode
      assign bspd = (beta_speed[3*p +: 3] > maxspd_r) ?
                    maxspd_r : beta_speed[3*p +: 3];
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          negspd_r <= SPEED_S100;
        else if (beta_s && con_r && !con_q_r)
          negspd_r <= bspd;
        else if (!beta_s && selfid_speed_load[p])
          negspd_r <= selfid_speed[3*p +: 3];
      end

      // bad codeword count; a read clear still counts a same-cycle error
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          badcnt_r <= 8'h0;
        else if ((acc_rd && sel && idx == IDX_BAD_CODEWORD) ||
                 remote_count_read[p])
          badcnt_r <= {7'h0, invalid_codeword[p]};
        else if (invalid_codeword[p] && badcnt_r != BAD_COUNT_MAX)
          badcnt_r <= badcnt_r + 8'h1;
      end

      // receive-ok, role shown as child when the port is idle
      assign rx_ok = beta_s ? (valid_s & ~tonly_s)
                            : (bias_s & con_r);
      assign role  = ~con_r | dis_r | fault_r | role_s;
      assign event_hit[p] = port_event[p] & ie_r;

      // readable views, reserved bits zero
      always_comb
      begin
        view[p][0] = 8'h0;
        view[p][0][FIRST_PAIR_LSB +: 2]  = {fp1, fp0};
        view[p][0][SECOND_PAIR_LSB +: 2] = {sp1, sp0};
        view[p][0][ROLE_BIT]       = role;
        view[p][0][CONNECT_BIT]    = con_r;
        view[p][0][RECEIVE_OK_BIT] = rx_ok & con_r & ~dis_r;
        view[p][0][DISABLE_BIT]    = dis_r;
        view[p][1] = 8'h0;
        view[p][1][NEG_SPEED_LSB +: 3] = negspd_r;
        view[p][1][IRQ_ENABLE_BIT]     = ie_r;
        view[p][1][FAULT_BIT]          = fault_r;
        view[p][1][STANDBY_ERR_BIT]    = stby_flt_r;
        view[p][1][SCRAMBLE_OFF_BIT]   = scr_r;
        view[p][1][BETA_ONLY_BIT]      = BETA_ONLY_VALUE;
        view[p][2] = 8'h0;
        view[p][2][DIRECT_ATTACH_BIT]   = dca_s;
        view[p][2][MAX_SPEED_LSB +: 3]  = maxspd_r;
        view[p][2][LOCAL_PLUG_BIT]      = LOCAL_PLUG_VALUE;
        view[p][2][CABLE_SPEED_LSB +: 3] = CABLE_SPEED;
        view[p][3] = 8'h0;
        view[p][3][UNRELIABLE_BIT] = unrel_r;
        view[p][3][BETA_MODE_BIT]  = beta_s & con_r;
        view_loop[p] = 8'h0;
        view_loop[p][LOOP_DISABLE_BIT] = loop_s & con_r;
        view_loop[p][IN_STANDBY_BIT]   = stby_s;
        view_loop[p][HARD_DISABLE_BIT] = hdis_s;
      end
      assign view_cnt[p] = badcnt_r;

      // port controls: disabled ports tone but never go active
      assign port_disable[p]          = dis_r;
      assign scramble_off[p]          = scr_r;
      assign port_suspend[p]          = fault_r;
      assign max_speed_limit[3*p +: 3] = maxspd_r;
      assign standby_err_clear[p]     = stby_clr_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // port event flag and link notification

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag_r <= 1'b0;
      notify_r   <= 1'b0;
    end
    else
    begin
      notify_r <= |event_hit;
      if (|event_hit)
        irq_flag_r <= 1'b1;
      else if (acc_wr && idx == IDX_IRQ_STATUS && wbyte[IRQ_FLAG_BIT])
        irq_flag_r <= 1'b0;
    end
  end

  assign port_event_irq_flag = irq_flag_r;
  assign link_notify         = notify_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses and absent ports read zero

  always_comb
  begin
    page_word = 8'h0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (page_ok && port_r == 4'(i))
      begin
        case (idx)
          IDX_LINE_CONNECT: page_word = view[i][0];
          IDX_SPEED_FAULT:  page_word = view[i][1];
          IDX_ATTACH_SPEED: page_word = view[i][2];
          IDX_LINK_QUALITY: page_word = view[i][3];
          IDX_BAD_CODEWORD: page_word = view_cnt[i];
          IDX_LOOP_STANDBY: page_word = view_loop[i];
          default:          page_word = 8'h0;
        endcase
      end
    end
    case (idx)
      IDX_IRQ_STATUS:  rd_byte = {7'h0, irq_flag_r};
      IDX_PAGE_SELECT: rd_byte = {page_r, 1'b0, port_r};
      default:         rd_byte = page_word;
    endcase
  end

  // read data captured in the wait cycle, stable in the answer cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 32'h0;
    else if (avs_read && !ack_r)
      rdata_r <= {24'h0, rd_byte};
  end

endmodule

`default_nettype wire

// ---- bench/psrp_monitor.sv ----
// assertion checker on the port status page ports
`timescale 1ns/100ps
`default_nettype none
module psrp_monitor
  import psrp_pkg::*;
#(
  parameter int NUM_PORTS = 3
)(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [6:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [NUM_PORTS-1:0] resume_fault,
  input wire logic [NUM_PORTS-1:0] port_event,
  input wire logic [NUM_PORTS-1:0] port_disable,
  input wire logic [NUM_PORTS-1:0] scramble_off,
  input wire logic [NUM_PORTS-1:0] port_suspend,
  input wire logic [NUM_PORTS-1:0] standby_err_clear,
  input wire logic                 port_event_irq_flag,
  input wire logic                 link_notify
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // bus answers, reserved reads, fixed bits
  wait_one_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait count");
  spare_zero_a: assert property (avs_read && avs_waitrequest &&
    avs_address[6:3] == 4'h7 |=> avs_readdata == 32'h0) else $error("spare");
  beta_only_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[6:2] == IDX_SPEED_FAULT |-> !avs_readdata[BETA_ONLY_BIT])
    else $error("beta only bit");
  // events, controls and faults
  notify_cause_a: assert property (link_notify |->
    port_event_irq_flag && $past(|port_event)) else $error("notify");
  flag_sticky_a: assert property ($fell(port_event_irq_flag) |->
    $past(avs_write)) else $error("flag fell");
  ctrl_hold_a: assert property (!$past(avs_write) |->
    $stable({port_disable, scramble_off})) else $error("control moved");
  fault_suspend_a: assert property ($rose(resume_fault[0]) |->
    ##[1:6] port_suspend[0]) else $error("no suspend");
  clear_pulse_a: assert property (standby_err_clear[0] |=>
    !standby_err_clear[0]) else $error("clear pulse");
  cover property (link_notify);
  cover property (port_suspend[0]);
  cover property (standby_err_clear[0]);
endmodule

bind psrp_port_status_page psrp_monitor #(.NUM_PORTS(NUM_PORTS)) mon_u (
  .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .resume_fault, .port_event, .port_disable, .scramble_off,
  .port_suspend, .standby_err_clear, .port_event_irq_flag, .link_notify);
`default_nettype wire

// ---- bench/psrp_port_model.sv ----
// behavioural port circuits and peers beyond the page
`timescale 1ns/100ps
`default_nettype none
module psrp_port_model
  import psrp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] plug,
  input  wire logic [2:0] beta,
  input  wire logic [2:0] quiet,
  output logic      [5:0] first_pair,
  output logic      [5:0] second_pair,
  output logic      [2:0] legacy_up,
  output logic      [2:0] beta_up,
  output logic      [2:0] neg_done,
  output logic      [2:0] tones_only,
  output logic      [2:0] signal_valid,
  output logic      [2:0] port_event,
  output logic      [8:0] beta_speed
);
  logic [2:0] plug_r;
  ////////////////////////////////////////
  // negotiation ends a cycle after tones start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      plug_r   <= 3'h0;
      neg_done <= 3'h0;
    end
    else
    begin
      plug_r   <= plug;
      neg_done <= plug & beta;
    end
  end
  // unplugged lines float: code 11
  assign first_pair =
    {~plug[2], 1'b1, ~plug[1], 1'b1, ~plug[0], 1'b1};
  assign second_pair =
    {1'b1, ~plug[2], 1'b1, ~plug[1], 1'b1, ~plug[0]};
  // legacy peer: bias and dc attach; beta peer: tones then signal
  assign legacy_up = plug & ~beta;
  assign beta_up = plug & beta;
  assign tones_only = plug & beta & quiet;
  assign signal_valid = plug & beta & ~quiet;
  assign port_event = plug ^ plug_r;
  assign beta_speed = {3{SPEED_S400}};
endmodule
`default_nettype wire

// ---- bench/port_status_register_page_tb.sv ----
// self-checking bench for the port status register page
`timescale 1ns/100ps
`default_nettype none
module port_status_register_page_tb
  import psrp_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [6:0]  avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [2:0]  plug = 3'h0, beta = 3'h0, quiet = 3'h2, role = 3'h2;
  logic [2:0]  res_f = 3'h0, sus_f = 3'h0, stby = 3'h0, stby_err = 3'h0;
  logic [2:0]  sid_load = 3'h0, bad_cw = 3'h0;
  logic [8:0]  sid_speed = 9'h0;
  logic        be_r = 1'b1;
  logic [31:0] avs_readdata;
  logic [5:0]  pair_a, pair_b;
  logic [8:0]  b_speed;
  logic [2:0]  leg_up, b_up, neg, t_only, s_valid, p_event, dis, scr, susp;
  logic        avs_waitrequest, irq_flag, notify;
  int          fail_count = 0, checked = 0, k;
  ////////////////////////////////////////
  // far side, then the page, short debounce
  psrp_port_model pm_u (.clk, .rst, .plug, .beta, .quiet, .first_pair(pair_a),
    .second_pair(pair_b), .legacy_up(leg_up), .beta_up(b_up), .neg_done(neg),
    .tones_only(t_only), .signal_valid(s_valid), .port_event(p_event),
    .beta_speed(b_speed));
  psrp_port_status_page #(.DEBOUNCE_CYC(16)) dut_u (.clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .first_pair(pair_a), .second_pair(pair_b),
    .downstream_role(role), .phys_connect(leg_up), .beta_mode(beta),
    .tones_seen(b_up), .tones_only(t_only), .speed_neg_done(neg),
    .cable_bias(leg_up), .signal_valid(s_valid),
    .direct_attach_detect(leg_up), .resume_fault(res_f),
    .suspend_fault(sus_f), .in_standby(stby), .standby_error(stby_err),
    .loop_disabled(leg_up), .hard_disabled(3'h0), .sync_failed(3'h0),
    .beta_speed(b_speed), .selfid_speed(sid_speed),
    .selfid_speed_load(sid_load), .port_event(p_event),
    .invalid_codeword(bad_cw), .remote_count_read(3'h0),
    .remote_standby_clear(3'h0), .port_disable(dis), .scramble_off(scr),
    .port_suspend(susp), .max_speed_limit(), .standby_err_clear(),
    .port_event_irq_flag(irq_flag), .link_notify(notify));
  always #20 clk = ~clk;
  // compare, verdict, waits
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t(input int n);
    repeat (n) @(posedge clk);
  endtask
  // request stands until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [4:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk);
    avs_address <= {i, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'h0, be_r};
    for (n = 0; n < 16 && (n == 0 || avs_waitrequest !== 1'b0); n++)
      @(posedge clk);
    q = avs_readdata[7:0];
    if (n == 16)
    begin
      fail_count++;
      print_verdict();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [4:0] i, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, i, 8'h00, q);
    chk(q, e);
  endtask
  ////////////////////////////////////////
  // scenarios
  initial
  begin
    t(8);
    rst <= 1'b0;
    t(2);
    rd(IDX_LINE_CONNECT, 8'hf8);
    rd(IDX_SPEED_FAULT, 8'h00);
    rd(IDX_ATTACH_SPEED, 8'h3b);
    wr(IDX_SPARE_A, 8'hff);
    rd(IDX_SPARE_A, 8'h00);
    rd(5'h1f, 8'h00);
    wr(IDX_SPEED_FAULT, 8'h12);
    wr(IDX_LINE_CONNECT, 8'h01);
    be_r = 1'b0;
    wr(IDX_LINE_CONNECT, 8'h00);
    be_r = 1'b1;
    @(negedge clk);
    chk({6'h0, scr[0], dis[0]}, 8'h03);
    rd(IDX_SPEED_FAULT, 8'h12);
    wr(IDX_LINE_CONNECT, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      wr(IDX_PAGE_SELECT, k == 0 ? 8'h03 : k == 1 ? 8'h20 : 8'h01);
      rd(IDX_SPEED_FAULT, 8'h00);
    end
    wr(IDX_PAGE_SELECT, 8'h00);
    // legacy connect on port 0
    plug[0] <= 1'b1;
    t(6);
    rd(IDX_LINE_CONNECT, 8'h68);
    t(30);
    rd(IDX_LINE_CONNECT, 8'h66);
    rd(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h01);
    rd(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_LINE_CONNECT, 8'h01);
    rd(IDX_LINE_CONNECT, 8'h6d);
    wr(IDX_LINE_CONNECT, 8'h00);
    sid_speed[2:0] <= SPEED_S200;
    sid_load[0] <= 1'b1;
    t(1);
    sid_load[0] <= 1'b0;
    rd(IDX_SPEED_FAULT, 8'h32);
    for (k = 0; k < 8; k++)
    begin
      wr(IDX_ATTACH_SPEED, 8'(k << 4));
      rd(IDX_ATTACH_SPEED,
         {1'b1, k > 3 ? 3'h3 : 3'(k), 4'hb});
    end
    // beta port 1: tones only, then signal
    wr(IDX_PAGE_SELECT, 8'h01);
    beta[1] <= 1'b1;
    plug[1] <= 1'b1;
    t(8);
    rd(IDX_LINE_CONNECT, 8'h6c);
    quiet[1] <= 1'b0;
    t(4);
    rd(IDX_LINE_CONNECT, 8'h6e);
    rd(IDX_SPEED_FAULT, 8'h40);
    wr(IDX_PAGE_SELECT, 8'h00);
    // both fault kinds suspend port 0 until cleared
    for (k = 0; k < 2; k++)
    begin
      res_f[0] <= k == 0;
      sus_f[0] <= k == 1;
      t(4);
      res_f[0] <= 1'b0;
      sus_f[0] <= 1'b0;
      rd(IDX_SPEED_FAULT, 8'h3a);
      @(negedge clk);
      chk({7'h0, susp[0]}, 8'h01);
      wr(IDX_SPEED_FAULT, 8'h1a);
      rd(IDX_SPEED_FAULT, 8'h32);
    end
    stby[0] <= 1'b1;
    stby_err[0] <= 1'b1;
    t(4);
    stby_err[0] <= 1'b0;
    rd(IDX_LOOP_STANDBY, 8'h06);
    rd(IDX_SPEED_FAULT, 8'h36);
    wr(IDX_SPEED_FAULT, 8'h16);
    rd(IDX_SPEED_FAULT, 8'h32);
    // error count saturates and clears on read
    bad_cw[0] <= 1'b1;
    t(3);
    bad_cw[0] <= 1'b0;
    rd(IDX_BAD_CODEWORD, 8'h03);
    bad_cw[0] <= 1'b1;
    t(300);
    bad_cw[0] <= 1'b0;
    rd(IDX_BAD_CODEWORD, 8'hff);
    rd(IDX_BAD_CODEWORD, 8'h00);
    rst <= 1'b1;
    t(2);
    rst <= 1'b0;
    t(2);
    rd(IDX_LINE_CONNECT, 8'h68);
    print_verdict();
  end
endmodule
`default_nettype wire
